// file: pkg/cssc_pkg.sv
// Constants, field layouts and enumerations for the clock source and start-up control block
package cssc_pkg;
   // APB register byte offsets
   localparam logic [11:0] CSSC_CTRL_OFS = 12'h000;
   localparam logic [11:0] CSSC_STATUS_OFS = 12'h004;
   localparam logic [11:0] CSSC_FUSE_OFS = 12'h008;
   localparam logic [11:0] CSSC_TRIM_OFS = 12'h00c;
   // Control register fields
   localparam int CSSC_CTRL_MODE_LSB = 0;
   localparam int CSSC_CTRL_GO_BIT = 8;
   // Status register fields
   localparam int CSSC_STAT_STATE_LSB = 0;
   localparam int CSSC_STAT_DONE_BIT = 8;
   localparam int CSSC_STAT_EN_LSB = 9;
   // Fuse readback fields
   localparam int CSSC_FUSE_SRC_LSB = 0;
   localparam int CSSC_FUSE_SUT_LSB = 4;
   localparam int CSSC_FUSE_AMP_BIT = 6;
   // Unprogrammed fuse defaults (one means unprogrammed)
   localparam logic [3:0] CSSC_SRC_DEFAULT = 4'h1;
   localparam logic [1:0] CSSC_SUT_DEFAULT = 2'h2;
   localparam logic CSSC_AMP_DEFAULT = 1'b1;
   localparam logic [7:0] CSSC_TRIM_RESET = 8'h00;
   // Clock source field boundaries
   localparam logic [3:0] CSSC_XTAL_MIN = 4'ha;
   localparam logic [3:0] CSSC_LFXTAL_CODE = 4'h9;
   localparam logic [3:0] CSSC_EXTRC_MIN = 4'h5;
   localparam logic [3:0] CSSC_INTRC_MIN = 4'h1;
   // Source cycle counts for wake start-up
   localparam int CSSC_CK_6 = 6;
   localparam int CSSC_CK_18 = 18;
   localparam int CSSC_CK_258 = 258;
   localparam int CSSC_CK_1K = 1024;
   localparam int CSSC_CK_16K = 16384;
   localparam int CSSC_CK_32K = 32768;
   // Watchdog oscillator cycles of the reset delay
   localparam int CSSC_WDT_SHORT = 4096;
   localparam int CSSC_WDT_LONG = 65536;
   // Crystal frequency range codes
   localparam logic [2:0] CSSC_RANGE_NONE = 3'h0;
   localparam logic [2:0] CSSC_RANGE_0P4 = 3'h1;
   localparam logic [2:0] CSSC_RANGE_0P9 = 3'h2;
   localparam logic [2:0] CSSC_RANGE_3P0 = 3'h3;
   localparam logic [2:0] CSSC_RANGE_WIDE = 3'h4;
   // Selected clock source kind
   typedef enum logic [2:0] {
      CSSC_SRC_XTAL = 3'h0, CSSC_SRC_LFXTAL = 3'h1, CSSC_SRC_EXTRC = 3'h2,
      CSSC_SRC_INTRC = 3'h3, CSSC_SRC_EXTCLK = 3'h4
   } cssc_src_t;
   // Wake start-up length code
   typedef enum logic [2:0] {
      CSSC_W6 = 3'h0, CSSC_W18 = 3'h1, CSSC_W258 = 3'h2,
      CSSC_W1K = 3'h3, CSSC_W16K = 3'h4, CSSC_W32K = 3'h5
   } cssc_wake_t;
   // Reset delay code
   typedef enum logic [1:0] {
      CSSC_DLY_NONE = 2'h0, CSSC_DLY_SHORT = 2'h1, CSSC_DLY_LONG = 2'h2
   } cssc_dly_t;
   // Sleep modes
   typedef enum logic [2:0] {
      CSSC_M_IDLE = 3'h0, CSSC_M_ADCNR = 3'h1, CSSC_M_PDOWN = 3'h2, CSSC_M_PSAVE = 3'h3,
      CSSC_M_STANDBY = 3'h6, CSSC_M_EXTSTBY = 3'h7
   } cssc_mode_t;
   // Sequencer states, one-hot
   typedef enum logic [5:0] {
      CSSC_ST_FUSE = 6'h01, CSSC_ST_SRC = 6'h02, CSSC_ST_WDT = 6'h04,
      CSSC_ST_RUN = 6'h08, CSSC_ST_SLEEP = 6'h10, CSSC_ST_SPARE = 6'h20
   } cssc_state_t;
endpackage

// file: verilog/cssc_clock_control.sv
// Clock source decode, start-up sequencing and clock domain gating with APB registers
`timescale 1ns/1ps

// What this block does
// - Stop unused domain clocks per sleep mode
// - Core clock off freezes core state
// - Async interrupt detect while peripheral clock stopped
// - Two-wire address match stays asynchronous
// - Program memory clock follows core clock
// - Async timer domain runs in idle, noise-reduction, power-save and extended standby sleep
// - Converter domain alive in noise-reduction sleep
// - Decode four-bit clock source field
// - Fuse one unprogrammed, zero programmed
// - Count source start-up on deep wake
// - Add watchdog-oscillator delay after reset
// - Defaults: internal RC, longest start-up
// - Crystal range from bits three to one
// - Bank bit plus start-up field pick timing
// - Bank zero: 258 or 1K cycles
// - Bank one: 1K or 16K cycles
// - Internal RC nominal frequency per code
// - Load factory trim on the first edge after reset release
module cssc_clock_control #(
   parameter int CK_16K = cssc_pkg::CSSC_CK_16K,
   parameter int CK_32K = cssc_pkg::CSSC_CK_32K,
   parameter int WDT_SHORT = cssc_pkg::CSSC_WDT_SHORT,
   parameter int WDT_LONG = cssc_pkg::CSSC_WDT_LONG
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [3:0] fuse_clock_source_select,
   input wire logic [1:0] fuse_startup_time_select,
   input wire logic fuse_amplifier_option,
   input wire logic [7:0] factory_trim,
   input wire logic source_tick,
   input wire logic watchdog_tick,
   input wire logic wake_event,
   output logic core_clock_en,
   output logic peripheral_clock_en,
   output logic program_memory_clock_en,
   output logic async_timer_clock_en,
   output logic converter_clock_en,
   output logic async_wake_logic_en,
   output cssc_pkg::cssc_src_t clock_source_kind,
   output logic [2:0] crystal_range,
   output logic [1:0] internal_rc_freq,
   output logic [7:0] oscillator_trim,
   output logic startup_done
);
   import cssc_pkg::*;

   // Counters hold the largest count; wider values cannot be served
   localparam int CW = 17;
   if (CK_16K < 1 || CK_32K < 1 || WDT_SHORT < 1 || WDT_LONG < 1 ||
       CK_32K >= 2**CW || WDT_LONG >= 2**CW) begin : g_bad_count
      $error("cssc_clock_control: count parameter out of range");
   end

   ////////////////////////////////////////////////////////////////////////////
   // State
   cssc_state_t state, next_state;
   logic from_reset, next_from_reset;        // Start-up follows a reset
   logic [CW-1:0] count, next_count;         // Down counter, source or watchdog
   logic [3:0] clock_source_select;          // Sampled fuse fields
   logic [1:0] startup_time_select;
   logic amplifier_option;
   logic [3:0] next_clock_source_select;
   logic [1:0] next_startup_time_select;
   logic next_amplifier_option;
   logic [2:0] sleep_mode, next_sleep_mode;  // Mode used at sleep entry
   logic [7:0] next_oscillator_trim;
   logic [4:0] domain_en, next_domain_en;    // core, periph, progmem, async, conv
   logic [31:0] next_prdata;
   logic next_pslverr;
   logic crystal_startup_bank;
   cssc_src_t src_kind;
   cssc_wake_t wake_code;
   cssc_dly_t dly_code;
   logic [CW-1:0] wake_len, dly_len;
   logic mapped, wr_access, go_req;

   ////////////////////////////////////////////////////////////////////////////
   // Fuse decode
   assign crystal_startup_bank = clock_source_select[0];

   // all-ones means unprogrammed, compares use raw codes
   always_comb begin
      if (clock_source_select >= CSSC_XTAL_MIN) begin
         src_kind = CSSC_SRC_XTAL;
      end else if (clock_source_select == CSSC_LFXTAL_CODE) begin
         src_kind = CSSC_SRC_LFXTAL;
      end else if (clock_source_select >= CSSC_EXTRC_MIN) begin
         src_kind = CSSC_SRC_EXTRC;
      end else if (clock_source_select >= CSSC_INTRC_MIN) begin
         src_kind = CSSC_SRC_INTRC;
      end else begin
         src_kind = CSSC_SRC_EXTCLK;
      end
   end

   // Start-up table per source; defaults before the case are the six-cycle row with the long delay
   always_comb begin
      wake_code = CSSC_W6;
      dly_code = CSSC_DLY_LONG;
      unique case (src_kind)
         CSSC_SRC_XTAL: begin
            unique case ({crystal_startup_bank, startup_time_select})
               3'h0: begin wake_code = CSSC_W258; dly_code = CSSC_DLY_SHORT; end
               3'h1: begin wake_code = CSSC_W258; dly_code = CSSC_DLY_LONG; end
               3'h2: begin wake_code = CSSC_W1K; dly_code = CSSC_DLY_NONE; end
               3'h3: begin wake_code = CSSC_W1K; dly_code = CSSC_DLY_SHORT; end
               3'h4: begin wake_code = CSSC_W1K; dly_code = CSSC_DLY_LONG; end
               3'h5: begin wake_code = CSSC_W16K; dly_code = CSSC_DLY_NONE; end
               3'h6: begin wake_code = CSSC_W16K; dly_code = CSSC_DLY_SHORT; end
               3'h7: begin wake_code = CSSC_W16K; dly_code = CSSC_DLY_LONG; end
            endcase
         end
         CSSC_SRC_LFXTAL: begin
            wake_code = (startup_time_select[1]) ? CSSC_W32K : CSSC_W1K;
            dly_code = (startup_time_select == 2'h0) ? CSSC_DLY_SHORT : CSSC_DLY_LONG;
         end
         CSSC_SRC_EXTRC: begin
            wake_code = (startup_time_select == 2'h3) ? CSSC_W6 : CSSC_W18;
            unique case (startup_time_select)
               2'h0: dly_code = CSSC_DLY_NONE;
               2'h2: dly_code = CSSC_DLY_LONG;
               default: dly_code = CSSC_DLY_SHORT;
            endcase
         end
         // Internal RC and external clock share the six-cycle rows
         CSSC_SRC_INTRC, CSSC_SRC_EXTCLK: begin
            wake_code = CSSC_W6;
            unique case (startup_time_select)
               2'h0: dly_code = CSSC_DLY_NONE;
               2'h1: dly_code = CSSC_DLY_SHORT;
               default: dly_code = CSSC_DLY_LONG;
            endcase
         end
      endcase
   end

   // Code to cycle counts
   always_comb begin
      unique case (wake_code)
         CSSC_W6: wake_len = CW'(CSSC_CK_6);
         CSSC_W18: wake_len = CW'(CSSC_CK_18);
         CSSC_W258: wake_len = CW'(CSSC_CK_258);
         CSSC_W1K: wake_len = CW'(CSSC_CK_1K);
         CSSC_W16K: wake_len = CW'(CK_16K);
         default: wake_len = CW'(CK_32K);
      endcase
      dly_len = (dly_code == CSSC_DLY_LONG) ? CW'(WDT_LONG) : CW'(WDT_SHORT);
   end

   // crystal range; internal RC frequency select
   // Lowest range is resonator only and 258 rows unfit for crystals configurer's duty
   always_comb begin
      crystal_range = CSSC_RANGE_NONE;
      if (src_kind == CSSC_SRC_XTAL) begin
         if (!amplifier_option) begin
            crystal_range = CSSC_RANGE_WIDE;
         end else begin
            unique case (clock_source_select[3:1])
               3'h5: crystal_range = CSSC_RANGE_0P4;
               3'h6: crystal_range = CSSC_RANGE_0P9;
               default: crystal_range = CSSC_RANGE_3P0;
            endcase
         end
      end
      internal_rc_freq = (src_kind == CSSC_SRC_INTRC) ? 2'(clock_source_select - CSSC_INTRC_MIN) : 2'h0;
   end
   assign clock_source_kind = src_kind;

   ////////////////////////////////////////////////////////////////////////////
   // APB decode
   assign mapped = (paddr == CSSC_CTRL_OFS) || (paddr == CSSC_STATUS_OFS) ||
                   (paddr == CSSC_FUSE_OFS) || (paddr == CSSC_TRIM_OFS);
   assign wr_access = psel && penable && pwrite && mapped;
   assign go_req = wr_access && (paddr == CSSC_CTRL_OFS) && pwdata[CSSC_CTRL_GO_BIT];
   assign pready = 1'b1;

   ////////////////////////////////////////////////////////////////////////////
   // Sequencer and register next values
   always_comb begin
      next_state = state;
      next_from_reset = from_reset;
      next_count = count;
      next_clock_source_select = clock_source_select;
      next_startup_time_select = startup_time_select;
      next_amplifier_option = amplifier_option;
      next_sleep_mode = sleep_mode;
      next_oscillator_trim = oscillator_trim;
      unique case (state)
         // fuses captured once, first edge after reset release
         CSSC_ST_FUSE: begin
            next_clock_source_select = fuse_clock_source_select;
            next_startup_time_select = fuse_startup_time_select;
            next_amplifier_option = fuse_amplifier_option;
            next_oscillator_trim = factory_trim;
            next_state = CSSC_ST_SPARE;
         end
         // One cycle for the decode to settle on the captured fuses
         CSSC_ST_SPARE: begin
            next_count = wake_len;
            next_state = CSSC_ST_SRC;
         end
         // count cycles of the selected source
         CSSC_ST_SRC: begin
            if (source_tick) begin
               next_count = count - CW'(1);
               if (count == CW'(1)) begin
                  next_count = dly_len;
                  // reset path adds the watchdog delay
                  if (from_reset && dly_code != CSSC_DLY_NONE) begin
                     next_state = CSSC_ST_WDT;
                  end else begin
                     next_state = CSSC_ST_RUN;
                     next_from_reset = 1'b0;
                  end
               end
            end
         end
         CSSC_ST_WDT: begin
            if (watchdog_tick) begin
               next_count = count - CW'(1);
               if (count == CW'(1)) begin
                  next_state = CSSC_ST_RUN;
                  next_from_reset = 1'b0;
               end
            end
         end
         // Sleep request loses to a simultaneous wake
         CSSC_ST_RUN: begin
            if (go_req && !wake_event) begin
               next_state = CSSC_ST_SLEEP;
            end
         end
         CSSC_ST_SLEEP: begin
            if (wake_event) begin
               // deep modes restart the source count
               if (sleep_mode == CSSC_M_PDOWN || sleep_mode == CSSC_M_PSAVE) begin
                  next_count = wake_len;
                  next_state = CSSC_ST_SRC;
               end else begin
                  next_state = CSSC_ST_RUN;
               end
            end
         end
         default: next_state = CSSC_ST_FUSE;
      endcase
      // Mode and trim writes; mode is frozen while asleep
      if (wr_access && paddr == CSSC_CTRL_OFS && state != CSSC_ST_SLEEP) begin
         next_sleep_mode = pwdata[CSSC_CTRL_MODE_LSB +: 3];
      end
      if (wr_access && paddr == CSSC_TRIM_OFS && state != CSSC_ST_FUSE) begin
         next_oscillator_trim = pwdata[7:0];
      end
   end

   // Domain enables per state and sleep mode
   always_comb begin
      next_domain_en = 5'h00;
      if (next_state == CSSC_ST_RUN) begin
         next_domain_en = 5'h1f;
      end else if (next_state == CSSC_ST_SLEEP) begin
         // core held off in every sleep mode
         // async timer kept in idle, noise reduction, power-save and extended standby
         // converter kept in idle and noise reduction
         unique case (next_sleep_mode)
            CSSC_M_IDLE: next_domain_en = 5'b01011;
            CSSC_M_ADCNR: next_domain_en = 5'b00011;
            CSSC_M_PSAVE, CSSC_M_EXTSTBY: next_domain_en = 5'b00010;
            default: next_domain_en = 5'b00000;
         endcase
      end
      next_domain_en[2] = next_domain_en[4];
      // start-up states leave every domain gated
   end

   // Read data latched in the setup phase
   always_comb begin
      next_prdata = 32'h0000_0000;
      next_pslverr = 1'b0;
      if (psel && !penable) begin
         next_pslverr = !mapped;
         if (paddr == CSSC_CTRL_OFS) begin
            next_prdata[CSSC_CTRL_MODE_LSB +: 3] = sleep_mode;
         end else if (paddr == CSSC_STATUS_OFS) begin
            next_prdata[CSSC_STAT_STATE_LSB +: 6] = state;
            next_prdata[CSSC_STAT_DONE_BIT] = startup_done;
            next_prdata[CSSC_STAT_EN_LSB +: 5] = domain_en;
         end else if (paddr == CSSC_FUSE_OFS) begin
            next_prdata[CSSC_FUSE_SRC_LSB +: 4] = clock_source_select;
            next_prdata[CSSC_FUSE_SUT_LSB +: 2] = startup_time_select;
            next_prdata[CSSC_FUSE_AMP_BIT] = amplifier_option;
         end else if (paddr == CSSC_TRIM_OFS) begin
            next_prdata[7:0] = oscillator_trim;
         end
      end else begin
         next_prdata = prdata;
         next_pslverr = pslverr;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registers
   // defaults stand until the fuse capture edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= CSSC_ST_FUSE;
         from_reset <= 1'b1;
         count <= '0;
         clock_source_select <= CSSC_SRC_DEFAULT;
         startup_time_select <= CSSC_SUT_DEFAULT;
         amplifier_option <= CSSC_AMP_DEFAULT;
         sleep_mode <= CSSC_M_IDLE;
         oscillator_trim <= CSSC_TRIM_RESET;
         domain_en <= 5'h00;
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         state <= next_state;
         from_reset <= next_from_reset;
         count <= next_count;
         clock_source_select <= next_clock_source_select;
         startup_time_select <= next_startup_time_select;
         amplifier_option <= next_amplifier_option;
         sleep_mode <= next_sleep_mode;
         oscillator_trim <= next_oscillator_trim;
         domain_en <= next_domain_en;
         prdata <= next_prdata;
         pslverr <= next_pslverr;
      end
   end

   // gating outputs taken from registered enables
   assign core_clock_en = domain_en[4];
   assign peripheral_clock_en = domain_en[3];
   assign program_memory_clock_en = domain_en[2];
   assign async_timer_clock_en = domain_en[1];
   assign converter_clock_en = domain_en[0];
   assign startup_done = (state == CSSC_ST_RUN) || (state == CSSC_ST_SLEEP);
   // asynchronous detectors armed whenever peripheral clock stops
   assign async_wake_logic_en = !domain_en[3];
endmodule

// file: verif/cssc_osc_model.sv
// Oscillator-side model: selected-source and watchdog oscillator tick pulses
`timescale 1ns/1ps
module cssc_osc_model (
   input wire logic pclk,
   output logic source_tick = 1'b0,
   output logic watchdog_tick = 1'b0
);
   ////////////////////////////////////////////////////////////
   // n one-cycle ticks, gap cycles apart
   task automatic pulse(input bit wd, input int n, input int gap);
      for (int i = 0; i < n; i++) begin
         @(posedge pclk);
         if (wd) begin
            watchdog_tick <= 1'b1;
         end else begin
            source_tick <= 1'b1;
         end
         @(posedge pclk);
         watchdog_tick <= 1'b0;
         source_tick <= 1'b0;
         repeat (gap - 1) @(posedge pclk);
      end
   endtask
endmodule

// file: verif/cssc_clock_control_props.sv
// Concurrent checks on the ports of the clock source and start-up control block
`timescale 1ns/1ps
module cssc_props_chk
   import cssc_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic source_tick,
   input wire logic watchdog_tick,
   input wire logic wake_event,
   input wire logic core_clock_en,
   input wire logic peripheral_clock_en,
   input wire logic program_memory_clock_en,
   input wire logic async_timer_clock_en,
   input wire logic converter_clock_en,
   input wire logic async_wake_logic_en,
   input wire cssc_src_t clock_source_kind,
   input wire logic [2:0] crystal_range,
   input wire logic [1:0] internal_rc_freq,
   input wire logic [7:0] oscillator_trim,
   input wire logic startup_done
);
   // One clock domain
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Software write to the trim register
   logic trim_wr;
   assign trim_wr = psel && penable && pwrite && (paddr == CSSC_TRIM_OFS);
   ////////////////////////////////////////////////////////////
   chk_progmem_core: assert property (program_memory_clock_en == core_clock_en)
      else $error("program memory clock differs from core clock");
   chk_gated_early: assert property (!startup_done |-> !(core_clock_en || peripheral_clock_en
      || program_memory_clock_en || async_timer_clock_en || converter_clock_en))
      else $error("domain clock running before start-up done");
   chk_async_detect: assert property (async_wake_logic_en == !peripheral_clock_en)
      else $error("async detect not opposite to peripheral clock");
   chk_core_needs_all: assert property (core_clock_en |->
      peripheral_clock_en && async_timer_clock_en && converter_clock_en)
      else $error("core runs with another domain stopped");
   chk_wake_cause: assert property ($rose(core_clock_en) |->
      $past(source_tick) || $past(watchdog_tick) || $past(wake_event))
      else $error("core clock started without tick or wake");
   chk_done_drop: assert property ($fell(startup_done) |-> $past(wake_event))
      else $error("start-up done dropped without wake");
   chk_fuse_hold: assert property (startup_done |->
      $stable(clock_source_kind) && $stable(crystal_range) && $stable(internal_rc_freq))
      else $error("fuse decode changed after start-up");
   chk_trim_source: assert property ($changed(oscillator_trim) && $past(startup_done) |-> $past(trim_wr))
      else $error("trim changed without a write");
   chk_xtal_range: assert property (clock_source_kind != CSSC_SRC_XTAL |-> crystal_range == CSSC_RANGE_NONE)
      else $error("crystal range set for a non-crystal source");
   chk_rc_freq: assert property (clock_source_kind != CSSC_SRC_INTRC |-> internal_rc_freq == 2'h0)
      else $error("internal RC frequency set for another source");
   chk_apb_unmapped: assert property (psel && penable && (paddr[11:4] != 8'h00) |-> pready && pslverr)
      else $error("unmapped access without error");
   // Main scenarios
   cover property ($rose(startup_done));
   cover property ($fell(startup_done));
   cover property (async_timer_clock_en && !core_clock_en);
   cover property (psel && penable && pslverr);
endmodule

bind cssc_clock_control cssc_props_chk u_props (.*);

// file: verif/tb_top.sv
// Self-checking bench for the clock source and start-up control block
`timescale 1ns/1ps
module tb_top;
   import cssc_pkg::*;
   // Short counts for the long rows
   localparam int K16 = 20;
   localparam int K32 = 24;
   localparam int WS = 8;
   localparam int WL = 16;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready, pslverr, source_tick, watchdog_tick;
   logic [3:0] fsrc = 4'h1;
   logic [1:0] fsut = 2'h2;
   logic famp = 1'b1;
   logic wake_event = 1'b0;
   logic core_en, peri_en, prog_en, asy_en, conv_en, done, awl;
   cssc_src_t kind;
   logic [2:0] rng;
   logic [1:0] rcf;
   logic [7:0] trim;
   int fail_count = 0;
   int checks = 0;
   // {done, core, periph, progmem, async, conv}
   wire logic [5:0] st = {done, core_en, peri_en, prog_en, asy_en, conv_en};
   always #25 pclk = ~pclk;
   cssc_osc_model osc (.pclk(pclk), .source_tick(source_tick), .watchdog_tick(watchdog_tick));
   cssc_clock_control #(.CK_16K(K16), .CK_32K(K32), .WDT_SHORT(WS), .WDT_LONG(WL)) dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .fuse_clock_source_select(fsrc), .fuse_startup_time_select(fsut), .fuse_amplifier_option(famp),
      .factory_trim(8'h5a), .source_tick(source_tick), .watchdog_tick(watchdog_tick),
      .wake_event(wake_event), .core_clock_en(core_en), .peripheral_clock_en(peri_en),
      .program_memory_clock_en(prog_en), .async_timer_clock_en(asy_en), .converter_clock_en(conv_en),
      .async_wake_logic_en(awl), .clock_source_kind(kind), .crystal_range(rng), .internal_rc_freq(rcf),
      .oscillator_trim(trim), .startup_done(done));
   ////////////////////////////////////////////////////////////
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // One APB transfer, held until pready is seen high
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic er);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Reset with given fuse levels
   task automatic rst(input logic [3:0] s, input logic [1:0] u, input logic a);
      @(posedge pclk);
      presetn <= 1'b0;
      fsrc <= s;
      fsut <= u;
      famp <= a;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      repeat (2) @(posedge pclk);
   endtask
   // Decode, then n source and m watchdog ticks
   task automatic run_startup(input logic [3:0] s, input logic [1:0] u, input logic a, input cssc_src_t k,
                              input logic [2:0] r, input logic [1:0] f, input int n, input int m);
      rst(s, u, a);
      cmp(32'(trim), 32'h5a);
      cmp({24'h0, 3'(kind), rng, rcf}, {24'h0, 3'(k), r, f});
      osc.pulse(1'b0, n - 1, 1);
      @(negedge pclk);
      cmp(32'(st), 32'h0);
      osc.pulse(1'b0, 1, 1);
      if (m != 0) begin
         @(negedge pclk);
         cmp(32'(st), 32'h0);
         osc.pulse(1'b1, m - 1, 3);
         @(negedge pclk);
         cmp(32'(st), 32'h0);
         osc.pulse(1'b1, 1, 3);
      end
      @(negedge pclk);
      cmp(32'(st), 32'h3f);
   endtask
   // Sleep, check domains, wake, check restart
   task automatic sleep_cycle(input logic [2:0] md, input logic [4:0] en, input bit deep);
      logic [31:0] rd;
      logic er;
      apb(1'b1, CSSC_CTRL_OFS, 32'h100 | 32'(md), rd, er);
      @(negedge pclk);
      cmp(32'(st), {26'h0, 1'b1, en});
      cmp(32'(awl), 32'(!en[3]));
      @(posedge pclk);
      wake_event <= 1'b1;
      @(posedge pclk);
      wake_event <= 1'b0;
      if (deep) begin
         @(negedge pclk);
         cmp(32'(st), 32'h0);
         osc.pulse(1'b0, 5, 2);
         @(negedge pclk);
         cmp(32'(st), 32'h0);
         osc.pulse(1'b0, 1, 2);
      end
      @(negedge pclk);
      cmp(32'(st), 32'h3f);
   endtask
   // Register map, unmapped address, held fuses
   task automatic reg_test();
      logic [31:0] rd;
      logic er;
      apb(1'b0, CSSC_STATUS_OFS, 32'h0, rd, er);
      cmp(rd, 32'h3f08);
      cmp(32'(er), 32'h0);
      fsrc <= 4'hf;
      fsut <= 2'h0;
      famp <= 1'b0;
      apb(1'b1, CSSC_FUSE_OFS, 32'hff, rd, er);
      apb(1'b0, CSSC_FUSE_OFS, 32'h0, rd, er);
      cmp(rd, 32'h61);
      cmp(32'(kind), 32'(CSSC_SRC_INTRC));
      apb(1'b0, CSSC_TRIM_OFS, 32'h0, rd, er);
      cmp(rd, 32'h5a);
      apb(1'b1, CSSC_TRIM_OFS, 32'ha5, rd, er);
      apb(1'b0, CSSC_TRIM_OFS, 32'h0, rd, er);
      cmp(rd, 32'ha5);
      apb(1'b1, CSSC_CTRL_OFS, 32'h1, rd, er);
      apb(1'b0, CSSC_CTRL_OFS, 32'h0, rd, er);
      cmp(rd, 32'h1);
      apb(1'b0, 12'h010, 32'h0, rd, er);
      cmp({rd[30:0], er}, 32'h1);
   endtask
   task automatic stop_test();
      $display("checks=%0d fail_count=%0d", checks, fail_count);
      if ((fail_count == 0) && (checks > 0)) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////
   initial begin
      repeat (16) @(posedge pclk);
      // Start-up for every source kind, both crystal banks; crystal 258-cycle rows on a resonator only
      run_startup(4'ha, 2'h0, 1'b1, CSSC_SRC_XTAL, CSSC_RANGE_0P4, 2'h0, 258, WS);
      run_startup(4'ha, 2'h1, 1'b1, CSSC_SRC_XTAL, CSSC_RANGE_0P4, 2'h0, 258, WL);
      run_startup(4'hc, 2'h2, 1'b1, CSSC_SRC_XTAL, CSSC_RANGE_0P9, 2'h0, 1024, 0);
      run_startup(4'he, 2'h3, 1'b1, CSSC_SRC_XTAL, CSSC_RANGE_3P0, 2'h0, 1024, WS);
      run_startup(4'hb, 2'h0, 1'b0, CSSC_SRC_XTAL, CSSC_RANGE_WIDE, 2'h0, 1024, WL);
      run_startup(4'hd, 2'h1, 1'b1, CSSC_SRC_XTAL, CSSC_RANGE_0P9, 2'h0, K16, 0);
      run_startup(4'hf, 2'h2, 1'b1, CSSC_SRC_XTAL, CSSC_RANGE_3P0, 2'h0, K16, WS);
      run_startup(4'hf, 2'h3, 1'b0, CSSC_SRC_XTAL, CSSC_RANGE_WIDE, 2'h0, K16, WL);
      run_startup(4'h9, 2'h2, 1'b1, CSSC_SRC_LFXTAL, CSSC_RANGE_NONE, 2'h0, K32, WL);
      run_startup(4'h5, 2'h3, 1'b1, CSSC_SRC_EXTRC, CSSC_RANGE_NONE, 2'h0, 6, WS);
      run_startup(4'h0, 2'h0, 1'b1, CSSC_SRC_EXTCLK, CSSC_RANGE_NONE, 2'h0, 6, 0);
      run_startup(4'h4, 2'h1, 1'b1, CSSC_SRC_INTRC, CSSC_RANGE_NONE, 2'h3, 6, WS);
      run_startup(4'h1, 2'h2, 1'b1, CSSC_SRC_INTRC, CSSC_RANGE_NONE, 2'h0, 6, WL);
      // Sleep modes, domains {core, peri, progmem, async, conv}
      sleep_cycle(3'h0, 5'b01011, 1'b0);
      sleep_cycle(3'h1, 5'b00011, 1'b0);
      sleep_cycle(3'h2, 5'b00000, 1'b1);
      sleep_cycle(3'h3, 5'b00010, 1'b1);
      sleep_cycle(3'h6, 5'b00000, 1'b0);
      sleep_cycle(3'h7, 5'b00010, 1'b0);
      reg_test();
      stop_test();
   end
   // Hang guard, a few times the run length
   initial begin
      repeat (50000) @(posedge pclk);
      fail_count++;
      stop_test();
   end
endmodule
